// File: pp_cmd_gen.sv
/*
 * Behavioural profile position command generator.
 * Assumes the bench calls send from one process only.
 */
module pp_cmd_gen (
	input wire sys_clk, // Clock.
	output logic [31:0] cmd_pos, // Command position.
	output logic cmd_pos_valid // Sample pulse.
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_pos = 32'h0000_0000;
		cmd_pos_valid = 1'b0;
	end
	// One absolute target a pulse; the data is scrambled between pulses.
	task automatic send(input int c);
		@(posedge sys_clk);
		cmd_pos <= c;
		cmd_pos_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_pos_valid <= 1'b0;
		cmd_pos <= ~c;
	endtask
endmodule

// File: wrap_coord_defs.vh
/*
 * Register offsets, field positions, reset values and fixed figures of the
 * wrap-coordinate unit.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef WRAP_COORD_DEFS_VH
`define WRAP_COORD_DEFS_VH

// ==========================================================================
// Byte offsets on the register bus
// ==========================================================================
`define OFS_CTRL 6'h00
`define OFS_RANGE 6'h04
`define OFS_RATIO 6'h08
`define OFS_STEP 6'h0C
`define OFS_GEAR_A 6'h10
`define OFS_GEAR_B 6'h14
`define OFS_SPAN_SEL 6'h18
`define OFS_CMD 6'h1C
`define OFS_STATUS 6'h20
`define OFS_SPAN_STEPS 6'h24
`define OFS_LOWER 6'h28

// ==========================================================================
// Field positions
// ==========================================================================
`define CTRL_EN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_MANUAL 3
`define CMD_CONFIG 0
`define CMD_CLR_ALARM 1
`define ST_ERR_INFO 0
`define ST_ALARM 1
`define ST_BUSY 2
`define ST_ACTIVE 3
`define SPAN_SEL_SMALL 0

// ==========================================================================
// Reset values and fixed figures (range and span in tenths of a revolution)
// ==========================================================================
`define RST_EN 1'b1
`define RST_MODE 2'h0
`define RST_MANUAL 1'b0
`define RST_RANGE 16'h4650
`define RST_RATIO 14'h1388
`define RST_STEP 30'h0000_0000
`define RST_GEAR 16'h0001
`define RST_SPAN_SMALL 1'b0
`define RATIO_MAX 14'h2710
`define SPAN_BIG_T 16'h4650
`define SPAN_SMALL_T 16'h2328
`define STEPS_PER_TENTH 48'h0000_0000_03E8
`define RATIO_FULL 48'h0000_0000_2710

`endif

// File: wrap_coord_unit.v
/*
 * Wrap-coordinate unit of one stepper axis: parameter registers on an
 * Avalon-MM slave, a range check, and folding of the command position.
 * Assumes the profile position generator gives one absolute command position
 * per valid pulse and moves less than one wrap span between two samples.
 */
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
// Contract
// R1: Wrap coordinate serves the wrap variants of profile position mode moves.
// R2: Mode code 0 absolute, 1 proximity, 2 forward, 3 reverse; default 0.
// R3: Host sets coordinate source to manual before wrap parameters apply.
// R4: Wrap enable: 0 off, 1 on; resets to 1.
// R5: Command position returns to zero after the wrap range; default 1,800 rev.
// R6: Offset ratio 0 to 10,000 in 0.01 percent, shifts range negative; default 5,000.
// R7: Signed step offset from -536,870,912 to 536,870,911; default zero.
// R8: Host picks the range from the listed values, 0.5 to 1,800.0 rev.
// R9: With a 900 rev sensor span host avoids unsupported larger ranges.
// R10: Sensor span divided by wrap range must be an integer.
// R11: Wrap range times resolution must be an integer.
// R12: Enabled wrap failing either integer check sets the error information flag.
// R13: While error information stands, wrapping is not performed.
// R14: Power-up or configuration with error information raises the wrap alarm.
// R15: Host should preset or home after changing enable or range.
// R16: A range that excludes home also sets the error information flag.
// R17: Span is range times resolution; lower bound is minus ratio span plus offset.
module wrap_coord_unit (
	input wire sys_clk, // System clock, 10 MHz.
	input wire rstn, // Asynchronous reset, active low.
	input wire [5:0] avs_address, // Byte address.
	input wire avs_read, // Read request.
	input wire avs_write, // Write request.
	input wire [31:0] avs_writedata, // Write data.
	input wire [3:0] avs_byteenable, // Byte enables.
	output reg [31:0] avs_readdata, // Read data.
	output wire avs_waitrequest, // Stall while the answer is prepared.
	input wire [31:0] cmd_pos, // Command position in steps.
	input wire cmd_pos_valid, // One-cycle pulse with a new command position.
	output reg [31:0] wrap_pos_ff, // Folded command position.
	output reg wrap_pos_valid_ff, // One-cycle pulse with wrap_pos_ff.
	output wire wrap_active, // Wrap coordinate in force.
	output wire [1:0] wrap_mode, // Wrap move style for the generator.
	output wire wrap_err_info, // Wrap setting error information.
	output reg wrap_alarm_ff // Wrap setting error alarm.
);

`include "wrap_coord_defs.vh"

	localparam S_IDLE = 5'b00001;
	localparam S_C1 = 5'b00010;
	localparam S_C2 = 5'b00100;
	localparam S_C3 = 5'b01000;
	localparam S_FIN = 5'b10000;

	// ======================================================================
	// Avalon-MM slave: one wait state, read data loaded during it
	// ======================================================================
	reg ack_ff;
	wire req = avs_read | avs_write;
	wire wr_go = avs_write & ack_ff;
	assign avs_waitrequest = req & ~ack_ff;

	reg en_ff;
	reg [1:0] mode_ff;
	reg manual_ff;
	reg [15:0] range_ff;
	reg [13:0] ratio_ff;
	reg [29:0] step_ff;
	reg [15:0] gear_a_ff;
	reg [15:0] gear_b_ff;
	reg span_small_ff;
	reg err_ff;
	reg [4:0] st_ff;
	reg [31:0] span_ff;
	reg [31:0] lower_ff;
	reg chk_req_ff;
	reg alarm_arm_ff;

	wire [31:0] wd = avs_writedata;
	wire lo_we = avs_byteenable[0] & avs_byteenable[1];
	wire full_we = &avs_byteenable;
	wire cfg_cmd = wr_go & (avs_address == `OFS_CMD) & avs_byteenable[0] & wd[`CMD_CONFIG];
	wire clr_alarm = wr_go & (avs_address == `OFS_CMD) & avs_byteenable[0] &
		wd[`CMD_CLR_ALARM];
	wire param_wr = wr_go & (avs_address != `OFS_CMD) & (avs_address < `OFS_STATUS);

	assign wrap_mode = mode_ff; // [R2]
	assign wrap_err_info = err_ff;
	// The check is idle exactly when the idle state bit is set.
	assign wrap_active = en_ff & ~err_ff & st_ff[0]; // [R13]

	reg [31:0] rd_nxt;
	always @* begin
		case (avs_address)
			`OFS_CTRL: rd_nxt = {28'h000_0000, manual_ff, mode_ff, en_ff};
			`OFS_RANGE: rd_nxt = {16'h0000, range_ff};
			`OFS_RATIO: rd_nxt = {18'h0_0000, ratio_ff};
			`OFS_STEP: rd_nxt = {{2{step_ff[29]}}, step_ff};
			`OFS_GEAR_A: rd_nxt = {16'h0000, gear_a_ff};
			`OFS_GEAR_B: rd_nxt = {16'h0000, gear_b_ff};
			`OFS_SPAN_SEL: rd_nxt = {31'h0000_0000, span_small_ff};
			`OFS_STATUS: rd_nxt = {28'h000_0000, wrap_active, ~st_ff[0], wrap_alarm_ff, err_ff};
			`OFS_SPAN_STEPS: rd_nxt = span_ff;
			`OFS_LOWER: rd_nxt = lower_ff;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_ff <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_ff <= req & ~ack_ff;
			if (avs_read & ~ack_ff) begin
				avs_readdata <= rd_nxt;
			end
		end
	end

	// ======================================================================
	// Parameter registers
	// ======================================================================
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			en_ff <= `RST_EN; // [R4]
			mode_ff <= `RST_MODE; // [R2]
			manual_ff <= `RST_MANUAL;
			range_ff <= `RST_RANGE; // [R5]
			ratio_ff <= `RST_RATIO; // [R6]
			step_ff <= `RST_STEP; // [R7]
			gear_a_ff <= `RST_GEAR;
			gear_b_ff <= `RST_GEAR;
			span_small_ff <= `RST_SPAN_SMALL;
		end else if (wr_go) begin
			case (avs_address)
				`OFS_CTRL: begin
					if (avs_byteenable[0]) begin
						en_ff <= wd[`CTRL_EN]; // [R4]
						mode_ff <= wd[`CTRL_MODE_HI:`CTRL_MODE_LO]; // [R2]
						manual_ff <= wd[`CTRL_MANUAL];
					end
				end
				`OFS_RANGE: if (lo_we) range_ff <= wd[15:0];
				`OFS_RATIO: begin
					// Ratios above 10,000 in the low 16 bits saturate; higher bits are dropped.
					if (lo_we) begin
						if (wd[15:0] > {2'b00, `RATIO_MAX}) begin
							ratio_ff <= `RATIO_MAX; // [R6]
						end else begin
							ratio_ff <= wd[13:0]; // [R6]
						end
					end
				end
				`OFS_STEP: if (full_we) step_ff <= wd[29:0]; // [R7]
				`OFS_GEAR_A: if (lo_we) gear_a_ff <= wd[15:0];
				`OFS_GEAR_B: if (lo_we) gear_b_ff <= wd[15:0];
				`OFS_SPAN_SEL: if (avs_byteenable[0]) span_small_ff <= wd[`SPAN_SEL_SMALL];
				default: ;
			endcase
		end
	end

	// ======================================================================
	// Range check: three divisions on one shared divider
	// ======================================================================
	reg div_start_ff;
	reg [47:0] div_num_ff;
	reg [47:0] div_den_ff;
	wire div_done;
	wire [47:0] div_quo;
	wire [47:0] div_rem;

	wrap_divider #(.WN(48), .WD(48)) u_div (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.start(div_start_ff),
		.num(div_num_ff),
		.den(div_den_ff),
		.busy_ff(),
		.done_ff(div_done),
		.quo_ff(div_quo),
		.rem_ff(div_rem)
	);

	// Without manual source the wrap parameters are held at their defaults.
	wire [15:0] eff_range = manual_ff ? range_ff : `RST_RANGE; // [R3]
	wire [13:0] eff_ratio = manual_ff ? ratio_ff : `RST_RATIO; // [R3]
	wire [29:0] eff_step = manual_ff ? step_ff : `RST_STEP; // [R3]
	wire [15:0] sensor_span = span_small_ff ? `SPAN_SMALL_T : `SPAN_BIG_T; // [R10]

	reg c1_ok_ff;
	reg c2_ok_ff;
	reg [47:0] span_q_ff;
	reg [13:0] ratio_l_ff;
	reg [29:0] step_l_ff;
	reg zero_ff;

	wire [47:0] lo_full = {{18{step_l_ff[29]}}, step_l_ff} - div_quo; // [R17]
	wire [47:0] hi_full = lo_full + span_q_ff;
	wire span_big = |span_q_ff[47:31];
	wire home_in = (lo_full[47] | (lo_full == 48'h0000_0000_0000)) & ~hi_full[47] &
		(hi_full != 48'h0000_0000_0000); // [R16]
	wire chk_bad = zero_ff | ~c1_ok_ff | ~c2_ok_ff | span_big | ~home_in; // [R12] [R16]

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= S_IDLE;
			chk_req_ff <= 1'b1;
			alarm_arm_ff <= 1'b1;
			div_start_ff <= 1'b0;
			div_num_ff <= 48'h0000_0000_0000;
			div_den_ff <= 48'h0000_0000_0000;
			c1_ok_ff <= 1'b0;
			c2_ok_ff <= 1'b0;
			span_q_ff <= 48'h0000_0000_0000;
			ratio_l_ff <= 14'h0000;
			step_l_ff <= 30'h0000_0000;
			zero_ff <= 1'b0;
			err_ff <= 1'b0;
			span_ff <= 32'h0000_0000;
			lower_ff <= 32'h0000_0000;
			wrap_alarm_ff <= 1'b0;
		end else begin
			div_start_ff <= 1'b0;
			// A request arriving mid-check is kept and runs the check again.
			if (param_wr | cfg_cmd) begin
				chk_req_ff <= 1'b1;
			end
			if (cfg_cmd) begin
				alarm_arm_ff <= 1'b1;
			end
			if (clr_alarm) begin
				wrap_alarm_ff <= 1'b0;
			end
			case (st_ff)
				S_IDLE: begin
					if (chk_req_ff & ~param_wr & ~cfg_cmd) begin
						chk_req_ff <= 1'b0;
						ratio_l_ff <= eff_ratio;
						step_l_ff <= eff_step;
						zero_ff <= (eff_range == 16'h0000) | (gear_a_ff == 16'h0000) |
							(gear_b_ff == 16'h0000);
						div_num_ff <= {32'h0000_0000, sensor_span}; // [R10]
						div_den_ff <= {32'h0000_0000, eff_range};
						div_start_ff <= 1'b1;
						st_ff <= S_C1;
					end
				end
				S_C1: begin
					if (div_done) begin
						c1_ok_ff <= (div_rem == 48'h0000_0000_0000); // [R10]
						div_num_ff <= {32'h0000_0000, eff_range} * `STEPS_PER_TENTH *
							{32'h0000_0000, gear_b_ff}; // [R11]
						div_den_ff <= {32'h0000_0000, gear_a_ff};
						div_start_ff <= 1'b1;
						st_ff <= S_C2;
					end
				end
				S_C2: begin
					if (div_done) begin
						c2_ok_ff <= (div_rem == 48'h0000_0000_0000); // [R11]
						span_q_ff <= div_quo; // [R17]
						div_num_ff <= {34'h0_0000_0000, ratio_l_ff} * div_quo; // [R6]
						div_den_ff <= `RATIO_FULL;
						div_start_ff <= 1'b1;
						st_ff <= S_C3;
					end
				end
				S_C3: begin
					if (div_done) begin
						err_ff <= en_ff & chk_bad; // [R12]
						span_ff <= span_q_ff[31:0];
						lower_ff <= lo_full[31:0];
						st_ff <= S_FIN;
					end
				end
				S_FIN: begin
					if (alarm_arm_ff & err_ff) begin
						wrap_alarm_ff <= 1'b1; // [R14]
					end
					alarm_arm_ff <= cfg_cmd;
					st_ff <= S_IDLE;
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	// ======================================================================
	// Position folding
	// ======================================================================
	reg [31:0] last_pos_ff;
	wire [31:0] delta = cmd_pos - last_pos_ff;
	wire [32:0] trial = {wrap_pos_ff[31], wrap_pos_ff} + {delta[31], delta};
	wire [32:0] low33 = {lower_ff[31], lower_ff};
	wire [32:0] high33 = low33 + {1'b0, span_ff};
	wire ge_high = ($signed(trial) >= $signed(high33));
	wire lt_low = ($signed(trial) < $signed(low33));
	wire [32:0] down = trial - {1'b0, span_ff};
	wire [32:0] up = trial + {1'b0, span_ff};

	// Only one span is added or taken per sample, so a jump of a span or more
	// between two samples is not folded fully.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			last_pos_ff <= 32'h0000_0000;
			wrap_pos_ff <= 32'h0000_0000;
			wrap_pos_valid_ff <= 1'b0;
		end else begin
			wrap_pos_valid_ff <= cmd_pos_valid;
			if (cmd_pos_valid) begin
				last_pos_ff <= cmd_pos;
				if (!wrap_active) begin
					wrap_pos_ff <= cmd_pos; // [R13]
				end else if (ge_high) begin
					wrap_pos_ff <= down[31:0]; // [R5] [R17]
				end else if (lt_low) begin
					wrap_pos_ff <= up[31:0]; // [R17]
				end else begin
					wrap_pos_ff <= trial[31:0]; // [R1]
				end
			end
		end
	end

endmodule

// File: wrap_coord_unit_assertions.sv
/*
 * Port checker of the wrap-coordinate unit.
 * Assumes a bind from the bench top onto the design top.
 */
module wrap_coord_unit_checker (
	input wire sys_clk, // Clock.
	input wire rstn, // Reset, active low.
	input wire [5:0] avs_address, // Address.
	input wire avs_read, // Read.
	input wire avs_write, // Write.
	input wire [31:0] avs_writedata, // Write data.
	input wire [3:0] avs_byteenable, // Lanes.
	input wire [31:0] avs_readdata, // Read data.
	input wire avs_waitrequest, // Stall.
	input wire [31:0] cmd_pos, // Command position.
	input wire cmd_pos_valid, // Sample pulse.
	input wire [31:0] wrap_pos_ff, // Folded position.
	input wire wrap_pos_valid_ff, // Folded pulse.
	input wire wrap_active, // Wrap in force.
	input wire [1:0] wrap_mode, // Move style.
	input wire wrap_err_info, // Error information.
	input wire wrap_alarm_ff // Alarm.
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire req = avs_read | avs_write;
	wire took_wr = avs_write & ~avs_waitrequest;
	// ====================================
	// Bus timing
	one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait state not one cycle");
	idle_nowait_a: assert property (!req |-> !avs_waitrequest)
		else $error("stall without a request");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	// ====================================
	// Position path, error handling and mode output
	pos_answer_a: assert property (cmd_pos_valid |=> wrap_pos_valid_ff)
		else $error("no folded sample after a command sample");
	pos_quiet_a: assert property (!cmd_pos_valid |=> !wrap_pos_valid_ff && $stable(wrap_pos_ff))
		else $error("folded output moved without a sample");
	bypass_pos_a: assert property (cmd_pos_valid && !wrap_active |=> wrap_pos_ff == $past(cmd_pos))
		else $error("position altered while wrap not in force");
	err_blocks_a: assert property (wrap_err_info |-> !wrap_active)
		else $error("wrap in force with error information");
	alarm_hold_a: assert property (wrap_alarm_ff && !(took_wr && avs_address == 6'h1C && avs_writedata[1]) |=> wrap_alarm_ff)
		else $error("alarm dropped without clear");
	alarm_cause_a: assert property ($rose(wrap_alarm_ff) |-> wrap_err_info)
		else $error("alarm without error information");
	mode_hold_a: assert property (!took_wr |=> $stable(wrap_mode))
		else $error("mode changed without a write");
endmodule

// File: wrap_coordinate_unit_tb_top.sv
/*
 * Self-checking bench of the wrap-coordinate unit.
 * Assumes the checker and the command generator are compiled first.
 */
module wrap_coordinate_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0;
	logic rstn = 0;
	logic [5:0] avs_address = 0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [3:0] avs_byteenable = 4'hF;
	wire [31:0] avs_readdata, cmd_pos, wrap_pos_ff;
	wire [1:0] wrap_mode;
	wire avs_waitrequest, cmd_pos_valid, wrap_pos_valid_ff, wrap_active, wrap_err_info, wrap_alarm_ff;
	int n_fail = 0;
	int num_checks = 0;
	int ex = 0;
	int lst = 0;
	bit act = 1;
	bit err;
	longint sp, lo;
	logic [31:0] q;
	// Rows: range in tenths, gear A, small span, step, ratio, manual, enable.
	int tab [12][7] = '{
		'{10, 1, 0, 0, 5000, 1, 1},
		'{144, 3, 0, 0, 5000, 1, 1},
		'{10, 3, 0, 0, 5000, 1, 1},
		'{10000, 1, 0, 0, 5000, 1, 1},
		'{10000, 1, 0, 0, 5000, 0, 1},
		'{10000, 1, 0, 0, 5000, 1, 0},
		'{18000, 1, 1, 0, 5000, 1, 1},
		'{9000, 1, 1, 0, 5000, 1, 1},
		'{10, 1, 0, 5000, 5000, 1, 1},
		'{10, 1, 0, 5001, 5000, 1, 1},
		'{10, 1, 0, -4999, 0, 1, 1},
		'{18000, 1, 0, -536870912, 20000, 1, 1}};
	always #50 sys_clk = ~sys_clk;
	wrap_coord_unit dut_u (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cmd_pos(cmd_pos), .cmd_pos_valid(cmd_pos_valid),
		.wrap_pos_ff(wrap_pos_ff), .wrap_pos_valid_ff(wrap_pos_valid_ff),
		.wrap_active(wrap_active), .wrap_mode(wrap_mode), .wrap_err_info(wrap_err_info),
		.wrap_alarm_ff(wrap_alarm_ff));
	pp_cmd_gen gen_u (.sys_clk(sys_clk), .cmd_pos(cmd_pos), .cmd_pos_valid(cmd_pos_valid));
	// ====================================
	// Checks and bus cycles
	task automatic print_verdict;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_pos;
		num_checks++;
		if (wrap_pos_ff !== ex || wrap_pos_valid_ff !== 1'b1 || wrap_active !== act) begin
			n_fail++;
			$display("mismatch %0t position %h expected %h", $time, wrap_pos_ff, ex);
		end
	endtask
	// Waitrequest and read data are taken at the rising edge that ends the request.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge sys_clk);
			t++;
		end while (avs_waitrequest && t < 50);
		q = avs_readdata;
		if (avs_waitrequest) begin
			n_fail++;
			$display("mismatch %0t bus request never answered", $time);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd_cmp(input logic [5:0] a, input logic [31:0] e);
		bus(0, a, 0);
		cmp_reg(q, e);
	endtask
	task automatic settle;
		repeat (100) begin
			bus(0, 6'h20, 0);
			if (!q[2]) break;
		end
		if (q[2]) begin
			n_fail++;
			$display("mismatch %0t range check never finished", $time);
		end
	endtask
	task automatic send(input int c);
		gen_u.send(c);
		@(negedge sys_clk);
		if (act) begin
			ex = ex + (c - lst);
			if (ex >= lo + sp) ex -= sp;
			else if (ex < lo) ex += sp;
		end else
			ex = c;
		lst = c;
		cmp_pos();
	endtask
	function automatic bit calc(int r, int ga, int sm, int st, int ra, int man, int en);
		longint sn;
		if (man == 0) begin
			r = 18000;
			ra = 5000;
			st = 0;
		end
		if (ra > 10000) ra = 10000;
		sn = sm ? 9000 : 18000;
		sp = longint'(r) * 1000 / ga;
		lo = st - longint'(ra) * sp / 10000;
		return en && (r == 0 || sn % r != 0 || r * 1000 % ga != 0
			|| sp >= 64'h0000_0000_8000_0000 || lo > 0 || lo + sp <= 0);
	endfunction
	// ====================================
	// Test sequence
	initial begin
		void'($urandom(32'h0000_04be));
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		rd_cmp(6'h00, 32'h0000_0001);
		rd_cmp(6'h04, 32'h0000_4650);
		rd_cmp(6'h08, 32'h0000_1388);
		rd_cmp(6'h0C, 32'h0000_0000);
		rd_cmp(6'h14, 32'h0000_0001);
		rd_cmp(6'h3C, 32'h0000_0000);
		avs_byteenable <= 4'h4;
		bus(1, 6'h04, 32'h0000_000A);
		avs_byteenable <= 4'hF;
		rd_cmp(6'h04, 32'h0000_4650);
		settle();
		rd_cmp(6'h20, 32'h0000_0008);
		rd_cmp(6'h24, 32'h0112_A880);
		rd_cmp(6'h28, 32'hFF76_ABC0);
		$display("end of reset test");
		for (int m = 0; m < 4; m++) begin
			bus(1, 6'h00, m * 2 + 1);
			@(negedge sys_clk);
			cmp_reg(wrap_mode, m);
		end
		$display("end of mode test");
		foreach (tab[i]) begin
			bus(1, 6'h00, tab[i][6] | tab[i][5] << 3);
			bus(1, 6'h04, tab[i][0]);
			bus(1, 6'h08, tab[i][4]);
			bus(1, 6'h0C, tab[i][3]);
			bus(1, 6'h10, tab[i][1]);
			bus(1, 6'h18, tab[i][2]);
			settle();
			err = calc(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4], tab[i][5], tab[i][6]);
			act = tab[i][6] && !err;
			rd_cmp(6'h20, {act, 2'b00, err});
			if (act) begin
				rd_cmp(6'h24, sp[31:0]);
				rd_cmp(6'h28, lo[31:0]);
				send(lst + int'(lo + sp - ex));
			end
			repeat (4) send(lst + int'($urandom % 19999) - 9999);
			$display("end of row %0d", i);
		end
		bus(1, 6'h1C, 32'h0000_0001);
		settle();
		rd_cmp(6'h20, 32'h0000_0003);
		bus(1, 6'h1C, 32'h0000_0002);
		settle();
		rd_cmp(6'h20, 32'h0000_0001);
		$display("end of alarm test");
		print_verdict();
	end
	initial begin
		#3_000_000;
		n_fail++;
		$display("mismatch %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
bind wrap_coord_unit wrap_coord_unit_checker chk_u (.sys_clk(sys_clk), .rstn(rstn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd_pos(cmd_pos),
	.cmd_pos_valid(cmd_pos_valid), .wrap_pos_ff(wrap_pos_ff),
	.wrap_pos_valid_ff(wrap_pos_valid_ff), .wrap_active(wrap_active), .wrap_mode(wrap_mode),
	.wrap_err_info(wrap_err_info), .wrap_alarm_ff(wrap_alarm_ff));

// File: wrap_divider.v
/*
 * Sequential restoring divider for unsigned operands, one quotient bit per
 * clock.
 * Assumes start is a one-cycle pulse given only while busy is low.
 */
module wrap_divider #(
	parameter WN = 48,
	parameter WD = 48
) (
	input wire sys_clk, // System clock.
	input wire rstn, // Asynchronous reset, active low.
	input wire start, // One-cycle pulse that loads operands.
	input wire [WN-1:0] num, // Dividend.
	input wire [WD-1:0] den, // Divisor; zero yields all-ones quotient.
	output reg busy_ff, // High while dividing.
	output reg done_ff, // One-cycle pulse when results are valid.
	output reg [WN-1:0] quo_ff, // Quotient.
	output reg [WD-1:0] rem_ff // Remainder.
);

	// ======================================================================
	// Shift and subtract
	// ======================================================================
	reg [WD-1:0] den_ff;
	localparam [7:0] CNT_INIT = WN;
	reg [7:0] cnt_ff;
	wire [WD:0] trial = {rem_ff, quo_ff[WN-1]};
	wire [WD:0] diff = trial - {1'b0, den_ff};

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			quo_ff <= {WN{1'b0}};
			rem_ff <= {WD{1'b0}};
			den_ff <= {WD{1'b0}};
			cnt_ff <= 8'h00;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				busy_ff <= 1'b1;
				quo_ff <= num;
				rem_ff <= {WD{1'b0}};
				den_ff <= den;
				cnt_ff <= CNT_INIT;
			end else if (busy_ff) begin
				if (!diff[WD]) begin
					rem_ff <= diff[WD-1:0];
					quo_ff <= {quo_ff[WN-2:0], 1'b1};
				end else begin
					rem_ff <= trial[WD-1:0];
					quo_ff <= {quo_ff[WN-2:0], 1'b0};
				end
				cnt_ff <= cnt_ff - 8'h01;
				if (cnt_ff == 8'h01) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
		end
	end

endmodule
